// ---- rtl/gpe_pkg.sv ----
// Constants shared by the general-purpose event logic
package event_logic_pkg;
    localparam int REG_W = 16;
    localparam int TERM_IN = 5;
    localparam int TERM_ALL = 7;
    localparam logic [7:0] STATUS_OFFSET = 8'ha8;
    localparam logic [7:0] ENABLE_OFFSET = 8'haa;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [15:0] ENABLE_RESET = 16'h0000;
    // Implemented bits: 15, 11, 8 and 4..0
    localparam logic [15:0] IMPL_MASK = 16'h891f;
    localparam int ZOOM_BIT = 15;
    localparam int POWER_BIT = 11;
    localparam int PROG12_BIT = 8;
    localparam logic [1:0] PRIME_CYCLES = 2'h3;
endpackage

// ---- rtl/change_if.sv ----
// Terminal levels in, change pulses out, between the event modules
`timescale 1ns/1ps
interface change_if;
    logic [4:0] level_raw;
    logic [4:0] change;
    logic primed;
    modport detector (input level_raw, output change, output primed);
    modport consumer (output level_raw, input change, input primed);
endinterface

// ---- rtl/input_change_detect.sv ----
// Synchroniser and level-change detector for the general input terminals
`timescale 1ns/1ps
module input_change_detect
    import event_logic_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    change_if.detector port
);
    logic [TERM_IN-1:0] sync_a;
    logic [TERM_IN-1:0] sync_b;
    logic [TERM_IN-1:0] last;
    logic [1:0] fill;
    logic [1:0] next_fill;
    logic [TERM_IN-1:0] next_change;
    logic [TERM_IN-1:0] change;

    // Hold off detection until the chain holds real levels
    always_comb begin
        next_fill = (fill == PRIME_CYCLES) ? fill : fill + 2'h1;
        next_change = (fill == PRIME_CYCLES) ? (sync_b ^ last) : '0;
    end

    // Two-flop synchroniser, history flop and change pulse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_a <= '0;
            sync_b <= '0;
            last <= '0;
            fill <= 2'h0;
            change <= '0;
        end else begin
            sync_a <= port.level_raw;
            sync_b <= sync_a;
            last <= sync_b;
            fill <= next_fill;
            change <= next_change;
        end
    end

    assign port.change = change;
    assign port.primed = (fill == PRIME_CYCLES);
endmodule

// ---- rtl/general_purpose_event_logic.sv ----
// General-purpose event status/enable registers and event pin driver
//
// Functional notes
// - Writing 1 to a status bit clears it and its event output, writing 0 leaves it.
// - Status bits latch their events regardless of the enable register.
// - Status bit 15 sets on any change of the zoomed-video enable bit.
// - Status bit 11 sets on any software change of the socket supply or programming voltage.
// - Status bit 8 sets when the programming-voltage request moves to or from 12 V.
// - Status bits 4..0 set on a level change of terminals 5, 4, 2, 1 and 0.
// - Reserved bits 14-12, 10-9 and 7-5 of both registers read zero and ignore writes.
// - The event output stays active until software clears the causing status bit.
// - The event reaches a pin only when a terminal among 6..0 is set up to carry it.
// - Enable bits 15, 11 and 8 gate the zoom, power and 12 V events.
// - Enable bits 4..0 gate input events only for terminals set up as general inputs.
// - Both registers reset to all zeros.
`timescale 1ns/1ps
module general_purpose_event_logic
    import event_logic_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] cfg_addr,
    input wire logic cfg_write,
    input wire logic cfg_read,
    input wire logic [1:0] cfg_byte_en,
    input wire logic [event_logic_pkg::REG_W-1:0] cfg_wdata,
    output logic [event_logic_pkg::REG_W-1:0] cfg_rdata,
    input wire logic zoomed_video_on,
    input wire logic [1:0] vcc_request,
    input wire logic [1:0] vpp_request,
    input wire logic vpp_is_12v,
    input wire logic multi_term_0,
    input wire logic multi_term_1,
    input wire logic multi_term_2,
    input wire logic multi_term_4,
    input wire logic multi_term_5,
    input wire logic [event_logic_pkg::TERM_IN-1:0] term_is_input,
    input wire logic [event_logic_pkg::TERM_ALL-1:0] term_is_event,
    output logic general_event_out_n,
    output logic [event_logic_pkg::TERM_ALL-1:0] event_pin_oe
);
    import event_logic_pkg::*;

    logic [REG_W-1:0] status;
    logic [REG_W-1:0] enable;
    logic [REG_W-1:0] next_status;
    logic [REG_W-1:0] next_enable;
    logic [REG_W-1:0] next_rdata;
    logic [REG_W-1:0] set_vec;
    logic [REG_W-1:0] clear_vec;
    logic [REG_W-1:0] allow_vec;
    logic [REG_W-1:0] pending;
    logic zoom_prev;
    logic [3:0] power_prev;
    logic prog12_prev;
    logic watch_ready;
    logic next_out_n;
    logic [TERM_ALL-1:0] next_oe;
    logic status_hit;
    logic enable_hit;

    change_if chg ();

    ////////////////////////////////////////////////////////////////////////
    // Byte enables widened to a bit mask, shared by both registers
    function automatic logic [REG_W-1:0] lane_mask(input logic [1:0] be);
        lane_mask = {{8{be[1]}}, {8{be[0]}}};
    endfunction

    // Terminal order: bit 4..0 follow terminals 5, 4, 2, 1, 0
    assign chg.level_raw = {multi_term_5, multi_term_4, multi_term_2,
                            multi_term_1, multi_term_0};

    input_change_detect detect (
        .clk(clk),
        .rst_n(rst_n),
        .port(chg.detector)
    );

    ////////////////////////////////////////////////////////////////////////
    // Event sources, compared with last cycle's value
    always_comb begin
        set_vec = '0;
        if (watch_ready) begin
            set_vec[ZOOM_BIT] = zoomed_video_on ^ zoom_prev;
            set_vec[POWER_BIT] = ({vcc_request, vpp_request} != power_prev);
            set_vec[PROG12_BIT] = vpp_is_12v ^ prog12_prev;
        end
        set_vec[TERM_IN-1:0] = chg.change;
    end

    // Register decode and write-one-to-clear
    always_comb begin
        status_hit = (cfg_addr == STATUS_OFFSET);
        enable_hit = (cfg_addr == ENABLE_OFFSET);
        clear_vec = '0;
        if (cfg_write && status_hit) begin
            clear_vec = cfg_wdata & lane_mask(cfg_byte_en);
        end
        // Set wins over a same-cycle clear; enable plays no part
        next_status = ((status & ~clear_vec) | set_vec) & IMPL_MASK;
        next_enable = enable;
        if (cfg_write && enable_hit) begin
            next_enable = ((cfg_wdata & lane_mask(cfg_byte_en))
                          | (enable & ~lane_mask(cfg_byte_en))) & IMPL_MASK;
        end
    end

    // Read mux, unmapped offsets return zero
    always_comb begin
        next_rdata = cfg_rdata;
        if (cfg_read) begin
            case (cfg_addr)
                STATUS_OFFSET: next_rdata = status;
                ENABLE_OFFSET: next_rdata = enable;
                default: next_rdata = '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event gating and pin drive
    always_comb begin
        allow_vec = IMPL_MASK;
        allow_vec[TERM_IN-1:0] = term_is_input;
        pending = status & enable & allow_vec;
        // Held while any gated status bit stays set
        next_out_n = !((|pending) && (|term_is_event));
        next_oe = (|pending) ? term_is_event : '0;
    end

    ////////////////////////////////////////////////////////////////////////
    // State registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status <= STATUS_RESET;
            enable <= ENABLE_RESET;
            cfg_rdata <= '0;
            zoom_prev <= 1'b0;
            power_prev <= 4'h0;
            prog12_prev <= 1'b0;
            watch_ready <= 1'b0;
            general_event_out_n <= 1'b1;
            event_pin_oe <= '0;
        end else begin
            status <= next_status;
            enable <= next_enable;
            cfg_rdata <= next_rdata;
            zoom_prev <= zoomed_video_on;
            power_prev <= {vcc_request, vpp_request};
            prog12_prev <= vpp_is_12v;
            watch_ready <= 1'b1;
            general_event_out_n <= next_out_n;
            event_pin_oe <= next_oe;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_status_reserved_zero: assert property (
        (status & ~IMPL_MASK) == 16'h0000)
        else $error("reserved status bit set");

    a_enable_reserved_zero: assert property (
        (enable & ~IMPL_MASK) == 16'h0000)
        else $error("reserved enable bit set");

    a_clear_by_one: assert property (
        (cfg_write && status_hit && cfg_byte_en[0] && cfg_wdata[0] && !set_vec[0])
        |=> !status[0])
        else $error("status bit 0 not cleared by write of one");

    a_zero_write_keeps: assert property (
        (cfg_write && status_hit && cfg_wdata == 16'h0000)
        |=> (status & $past(status)) == $past(status))
        else $error("write of zero changed status");

    a_latch_without_enable: assert property (
        (set_vec[POWER_BIT] && !enable[POWER_BIT]) |=> status[POWER_BIT])
        else $error("power event lost while disabled");

    a_zoom_toggle_sets: assert property (
        ($past(watch_ready) && $changed(zoomed_video_on)) |=> status[ZOOM_BIT])
        else $error("zoom change not latched");

    a_power_change_sets: assert property (
        ($past(watch_ready) && $changed({vcc_request, vpp_request}))
        |=> status[POWER_BIT])
        else $error("power change not latched");

    a_prog12_change_sets: assert property (
        ($past(watch_ready) && $changed(vpp_is_12v)) |=> status[PROG12_BIT])
        else $error("12 V request change not latched");

    a_terminal_change_sets: assert property (
        (chg.primed && $past(chg.primed) && $changed(multi_term_1)
         && !(cfg_write && status_hit))
        |-> ##[1:4] status[1])
        else $error("terminal 1 change not latched");

    a_event_holds: assert property (
        (!general_event_out_n && !cfg_write && !$past(cfg_write) && $stable(enable)
         && $stable(term_is_event) && $stable(term_is_input))
        |=> !general_event_out_n)
        else $error("event dropped without a clear");

    a_no_terminal_no_pin: assert property (
        (term_is_event == 7'h00) |=> (general_event_out_n && event_pin_oe == 7'h00))
        else $error("event driven with no event terminal");

    a_output_tracks_pending: assert property (
        general_event_out_n == !$past((|pending) && (|term_is_event)))
        else $error("event output disagrees with gated status");

    a_disabled_stays_quiet: assert property (
        ((status & enable) == 16'h0000) |=> general_event_out_n)
        else $error("event without an enabled status bit");

    a_input_config_gates: assert property (
        (((status & enable) & ~16'h001f) == 16'h0000
         && ((status & enable) & {11'h000, term_is_input}) == 16'h0000)
        |=> general_event_out_n)
        else $error("event from terminal not set up as input");

    c_zoom_event: cover property (
        $rose(status[ZOOM_BIT]) && enable[ZOOM_BIT] ##1 !general_event_out_n);
    c_terminal_event: cover property ($rose(status[4]));
    c_clear_releases: cover property (
        !general_event_out_n ##1 (cfg_write && status_hit) ##2 general_event_out_n);
endmodule

// ---- dv/pm_event_sink.sv ----
// System event input with pull-ups on the event terminals
`timescale 1ns/1ps
module pm_event_sink (
    input wire logic [6:0] event_pin_oe,
    output logic [6:0] pin_level,
    output logic wake
);
    // Released terminals float up to the pull-up level
    assign pin_level = ~event_pin_oe;
    // Any terminal pulled low wakes the system
    assign wake = ~&pin_level;
endmodule

// ---- dv/general_purpose_event_logic_bench.sv ----
// Self-checking bench for the general-purpose event logic
`timescale 1ns/1ps
module general_purpose_event_logic_bench;
    import event_logic_pkg::*;
    logic clk, rst_n, cfg_write, cfg_read, zoom, v12, event_n, wake;
    logic [7:0] cfg_addr;
    logic [1:0] cfg_byte_en, vcc, vpp;
    logic [15:0] cfg_wdata, cfg_rdata, en;
    logic [4:0] term, term_in;
    logic [6:0] term_ev, oe, pins;
    int mismatches, checks, seed, k;

    ////////////////////////////////////////////////////////////////
    general_purpose_event_logic DUT (.clk(clk), .rst_n(rst_n), .cfg_addr(cfg_addr),
        .cfg_write(cfg_write), .cfg_read(cfg_read), .cfg_byte_en(cfg_byte_en),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .zoomed_video_on(zoom),
        .vcc_request(vcc), .vpp_request(vpp), .vpp_is_12v(v12),
        .multi_term_0(term[0]), .multi_term_1(term[1]), .multi_term_2(term[2]),
        .multi_term_4(term[3]), .multi_term_5(term[4]), .term_is_input(term_in),
        .term_is_event(term_ev), .general_event_out_n(event_n), .event_pin_oe(oe));
    pm_event_sink host (.event_pin_oe(oe), .pin_level(pins), .wake(wake));

    // Free-running clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One write cycle, held across the taking edge
    task automatic wr(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
        @(negedge clk);
        cfg_addr = a;
        cfg_byte_en = be;
        cfg_wdata = d;
        cfg_write = 1'b1;
        @(negedge clk);
        cfg_write = 1'b0;
    endtask

    // One read cycle, data looked at after the taking edge
    task automatic rdc(input logic [7:0] a, input logic [15:0] exp, input string what);
        @(negedge clk);
        cfg_addr = a;
        cfg_read = 1'b1;
        @(negedge clk);
        cfg_read = 1'b0;
        chk(what, cfg_rdata, exp);
    endtask

    // Status bits expected from one event source
    function automatic logic [15:0] cause(input int i);
        if (i < 5) return 16'h0001 << i;
        if (i == 5) return 16'h8000;
        if (i == 6) return 16'h0800;
        return 16'h0900;
    endfunction

    // Make one event happen, then let it settle
    task automatic poke(input int i);
        @(negedge clk);
        if (i < 5) term[i] = ~term[i];
        else if (i == 5) zoom = ~zoom;
        else if (i == 6) vcc = vcc ^ 2'($urandom_range(3, 1));
        else begin
            v12 = ~v12;
            vpp = vpp ^ 2'h1;
        end
        repeat (5) @(negedge clk);
    endtask

    task automatic pin(input logic low, input logic [6:0] ev);
        chk("event_n", 16'(event_n), 16'(!low));
        chk("event_oe", 16'(oe), low ? 16'(ev) : 16'h0);
        chk("wake", 16'(wake), 16'(low));
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {rst_n, cfg_write, cfg_read, zoom, v12} = 5'h0;
        {cfg_addr, cfg_byte_en, vcc, vpp, cfg_wdata, term} = '0;
        seed = $urandom(28449);
        term_in = 5'h1f;
        term_ev = 7'($urandom_range(127, 1));
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        rdc(STATUS_OFFSET, STATUS_RESET, "status");
        rdc(ENABLE_OFFSET, ENABLE_RESET, "enable");
        wr(ENABLE_OFFSET, 2'h1, 16'hffff);
        rdc(ENABLE_OFFSET, 16'h001f, "enable");
        wr(ENABLE_OFFSET, 2'h3, 16'hffff);
        rdc(ENABLE_OFFSET, 16'h891f, "enable");
        rdc(8'hac, 16'h0, "unmapped");
        wr(ENABLE_OFFSET, 2'h3, 16'h0);
        // Every source latches with enables off
        for (int i = 0; i < 8; i++) begin
            poke(i);
            rdc(STATUS_OFFSET, cause(i), "status");
            pin(1'b0, term_ev);
            wr(STATUS_OFFSET, 2'h3, 16'hffff);
            rdc(STATUS_OFFSET, 16'h0, "status");
        end
        // Enabled events hold until their clear
        wr(ENABLE_OFFSET, 2'h3, 16'h891f);
        for (int i = 0; i < 8; i++) begin
            poke(i);
            pin(1'b1, term_ev);
            wr(STATUS_OFFSET, 2'h3, ~cause(i));
            pin(1'b1, term_ev);
            wr(STATUS_OFFSET, 2'h3, cause(i));
            @(negedge clk);
            pin(1'b0, term_ev);
        end
        // Terminal not set up as input, then no event terminal
        term_in = 5'h1b;
        poke(2);
        pin(1'b0, term_ev);
        rdc(STATUS_OFFSET, 16'h0004, "status");
        term_in = 5'h1f;
        repeat (2) @(negedge clk);
        pin(1'b1, term_ev);
        term_ev = 7'h0;
        repeat (2) @(negedge clk);
        pin(1'b0, 7'h0);
        wr(STATUS_OFFSET, 2'h3, 16'hffff);
        // Zoom event in the same cycle as its clear, then a write of zero
        poke(5);
        @(negedge clk);
        zoom = ~zoom;
        cfg_addr = STATUS_OFFSET;
        cfg_byte_en = 2'h3;
        cfg_wdata = 16'h8000;
        cfg_write = 1'b1;
        @(negedge clk);
        cfg_write = 1'b0;
        rdc(STATUS_OFFSET, 16'h8000, "status");
        wr(STATUS_OFFSET, 2'h3, 16'h0000);
        rdc(STATUS_OFFSET, 16'h8000, "status");
        wr(STATUS_OFFSET, 2'h3, 16'hffff);
        // Random sources against random enables
        term_ev = 7'h40;
        repeat (30) begin
            k = $urandom_range(7, 0);
            en = IMPL_MASK & 16'($urandom);
            wr(ENABLE_OFFSET, 2'h3, en);
            poke(k);
            pin(|(cause(k) & en), term_ev);
            wr(STATUS_OFFSET, 2'h3, 16'hffff);
        end
        tally_and_finish();
    end

    // Watchdog well beyond the expected run
    initial begin
        #400000;
        mismatches++;
        tally_and_finish();
    end
endmodule
